//--- core/ilc_pkg.sv
`default_nettype none
package ilc_pkg;
    localparam int          CLK_MHZ    = 100;
    localparam int          TICK_US    = 1000;
    localparam int          TICK_CYC   = TICK_US * CLK_MHZ;
    localparam int          ADDR_W     = 8;
    localparam logic [7:0]  CFG_ADDR   = 8'h14;
    localparam int          SEL1_LSB   = 12;
    localparam int          SEL2_LSB   = 8;
    localparam int          SEL3_LSB   = 4;
    localparam int          FREQ_LSB   = 2;
    localparam int          STR_BIT    = 1;
    localparam logic [3:0]  SEL1_RST   = 4'h0;
    localparam logic [3:0]  SEL2_RST   = 4'h4;
    localparam logic [3:0]  SEL3_RST   = 4'h2;
    localparam logic [1:0]  FREQ_RST   = 2'h0;
    localparam logic        STR_RST    = 1'b1;
    localparam logic [6:0]  STR0_MS    = 7'h1e;
    localparam logic [6:0]  STR1_MS    = 7'h3c;
    localparam logic [6:0]  STR2_MS    = 7'h64;
    localparam logic [7:0]  FAST_MS    = 8'h32;
    localparam logic [7:0]  SLOW_MS    = 8'hfa;
    localparam logic [3:0]  C_SPEED    = 4'h0;
    localparam logic [3:0]  C_TX       = 4'h1;
    localparam logic [3:0]  C_RX       = 4'h2;
    localparam logic [3:0]  C_COL      = 4'h3;
    localparam logic [3:0]  C_LINK     = 4'h4;
    localparam logic [3:0]  C_DUP      = 4'h5;
    localparam logic [3:0]  C_ACT      = 4'h7;
    localparam logic [3:0]  C_ON       = 4'h8;
    localparam logic [3:0]  C_OFF      = 4'h9;
    localparam logic [3:0]  C_FAST     = 4'ha;
    localparam logic [3:0]  C_SLOW     = 4'hb;
    localparam logic [3:0]  C_LR       = 4'hc;
    localparam logic [3:0]  C_LA       = 4'hd;
    localparam logic [3:0]  C_DC       = 4'he;
endpackage : ilc_pkg
`default_nettype wire

//--- core/ilc_top.sv
// Design decisions made here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Third indicator select picks speed, transmit, receive, collision, link, duplex, activity.
// - Codes 1000/1001 force on/off; 1010/1011 blink fast/slow.
// - Codes 1100, 1101, 1110 give link+receive, link+activity, duplex+collision.
// - Link modes solid on with link; events blink, activity even without link.
// - Duplex/collision mode on while linked and full-duplex, blinks on collision.
// - Combined modes always stretch regardless of the stretch-enable bit.
// - Stretch time field gives 30, 60, 100 ms; 11 reserved; resets 00.
// - One stretch-enable bit governs all indicators; resets to one.
// - First indicator select is bits 15:12, resets to speed.
// - Second indicator select is bits 11:8, resets to link.
// - Configuration register sits at address 20 decimal, 14 hex.
module ilc_top #(
    parameter int TICK_CYC_P = ilc_pkg::TICK_CYC
) (
    // Clock and reset.
    input  wire logic                        ref_clk_i,
    input  wire logic                        rstn_i,
    // Wishbone slave.
    input  wire logic [ilc_pkg::ADDR_W-1:0]  wb_adr_i,
    input  wire logic [31:0]                 wb_dat_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic                        wb_we_i,
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    output logic [31:0]                      wb_dat_o,
    output logic                             wb_ack_o,
    // Transceiver status.
    input  wire logic                        speed_i,
    input  wire logic                        tx_i,
    input  wire logic                        rx_i,
    input  wire logic                        col_i,
    input  wire logic                        link_i,
    input  wire logic                        duplex_i,
    // Indicator drives, high means lamp on.
    output logic                             ind1_o,
    output logic                             ind2_o,
    output logic                             ind3_o
);
    import ilc_pkg::*;

    localparam int DW = $clog2(TICK_CYC_P + 1);

    logic [15:0]    cfg_reg;
    logic [15:0]    cfg_next;
    logic           ack_reg;
    logic           ack_next;
    logic [31:0]    dat_reg;
    logic [31:0]    dat_next;
    logic [DW-1:0]  div_reg;
    logic [DW-1:0]  div_next;
    logic           tick_reg;
    logic           tick_next;
    logic [7:0]     fcnt_reg;
    logic [7:0]     fcnt_next;
    logic [7:0]     scnt_reg;
    logic [7:0]     scnt_next;
    logic           fb_reg;
    logic           fb_next;
    logic           sb_reg;
    logic           sb_next;
    logic [2:0][6:0] cnt_reg;
    logic [2:0][6:0] cnt_next;
    logic [2:0]     ind_reg;
    logic [2:0]     ind_next;
    logic [2:0][3:0] sel_w;
    logic [2:0]     ev_w;
    logic [2:0]     held_w;
    logic           hit;
    logic           adr_ok;
    logic           str_en;

    function automatic logic ev_of(input logic [3:0] c, input logic tx,
                                   input logic rx, input logic co);
        case (c)
            C_TX:    ev_of = tx;
            C_RX:    ev_of = rx;
            C_COL:   ev_of = co;
            C_ACT:   ev_of = rx | tx;
            C_LR:    ev_of = rx;
            C_LA:    ev_of = rx | tx;
            C_DC:    ev_of = co;
            default: ev_of = 1'b0;
        endcase
    endfunction : ev_of

    function automatic logic is_comb(input logic [3:0] c);
        is_comb = (c == C_LR) || (c == C_LA) || (c == C_DC);
    endfunction : is_comb

    function automatic logic [6:0] str_len(input logic [1:0] f);
        case (f)
            2'h0:    str_len = STR0_MS;
            2'h1:    str_len = STR1_MS;
            default: str_len = STR2_MS;
        endcase
    endfunction : str_len

    assign sel_w[0] = cfg_reg[SEL1_LSB +: 4];
    assign sel_w[1] = cfg_reg[SEL2_LSB +: 4];
    assign sel_w[2] = cfg_reg[SEL3_LSB +: 4];
    assign str_en   = cfg_reg[STR_BIT];
    assign hit      = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign adr_ok   = (wb_adr_i == CFG_ADDR);

    // Register bus: one answer per request, registered one clock later, bit 0 kept at zero.
    always_comb begin
        cfg_next = cfg_reg;
        ack_next = hit;
        dat_next = 32'h0;
        if (hit && adr_ok) begin
            if (wb_we_i) begin
                if (wb_sel_i[0]) begin
                    cfg_next[7:1] = wb_dat_i[7:1];
                end
                if (wb_sel_i[1]) begin
                    cfg_next[15:8] = wb_dat_i[15:8];
                end
            end else begin
                dat_next = {16'h0, cfg_reg[15:1], 1'b0};
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_reg <= {SEL1_RST, SEL2_RST, SEL3_RST, FREQ_RST, STR_RST, 1'b0};
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
        end else begin
            cfg_reg <= cfg_next;
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    // Millisecond tick and the two blink rates.
    always_comb begin
        div_next  = div_reg + DW'(1);
        tick_next = 1'b0;
        fcnt_next = fcnt_reg;
        scnt_next = scnt_reg;
        fb_next   = fb_reg;
        sb_next   = sb_reg;
        if (div_reg == DW'(TICK_CYC_P - 1)) begin
            div_next  = '0;
            tick_next = 1'b1;
        end
        if (tick_reg) begin
            fcnt_next = fcnt_reg + 8'h01;
            scnt_next = scnt_reg + 8'h01;
            if (fcnt_reg == FAST_MS - 8'h01) begin
                fcnt_next = 8'h00;
                fb_next   = ~fb_reg;
            end
            if (scnt_reg == SLOW_MS - 8'h01) begin
                scnt_next = 8'h00;
                sb_next   = ~sb_reg;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_reg  <= '0;
            tick_reg <= 1'b0;
            fcnt_reg <= 8'h00;
            scnt_reg <= 8'h00;
            fb_reg   <= 1'b0;
            sb_reg   <= 1'b0;
        end else begin
            div_reg  <= div_next;
            tick_reg <= tick_next;
            fcnt_reg <= fcnt_next;
            scnt_reg <= scnt_next;
            fb_reg   <= fb_next;
            sb_reg   <= sb_next;
        end
    end

    // Per-indicator stretch timer and source selection.
    always_comb begin
        cnt_next = cnt_reg;
        ind_next = ind_reg;
        ev_w     = '0;
        held_w   = '0;
        for (int i = 0; i < 3; i++) begin
            ev_w[i] = ev_of(sel_w[i], tx_i, rx_i, col_i);
            if (ev_w[i] && (str_en || is_comb(sel_w[i]))) begin
                cnt_next[i] = str_len(cfg_reg[FREQ_LSB +: 2]);
            end else if (tick_reg && cnt_reg[i] != 7'h00) begin
                cnt_next[i] = cnt_reg[i] - 7'h01;
            end
            held_w[i] = ev_w[i] |
                        ((str_en | is_comb(sel_w[i])) & (cnt_reg[i] != 7'h00));
            case (sel_w[i])
                C_SPEED: ind_next[i] = speed_i;
                C_TX:    ind_next[i] = held_w[i];
                C_RX:    ind_next[i] = held_w[i];
                C_COL:   ind_next[i] = held_w[i];
                C_LINK:  ind_next[i] = link_i;
                C_DUP:   ind_next[i] = duplex_i;
                C_ACT:   ind_next[i] = held_w[i];
                C_ON:    ind_next[i] = 1'b1;
                C_OFF:   ind_next[i] = 1'b0;
                C_FAST:  ind_next[i] = fb_reg;
                C_SLOW:  ind_next[i] = sb_reg;
                C_LR:    ind_next[i] = held_w[i] ? fb_reg : link_i;
                C_LA:    ind_next[i] = held_w[i] ? fb_reg : link_i;
                C_DC:    ind_next[i] = held_w[i] ? fb_reg : (link_i & duplex_i);
                default: ind_next[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg <= '0;
            ind_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
            ind_reg <= ind_next;
        end
    end

    assign wb_dat_o = dat_reg;
    assign wb_ack_o = ack_reg;
    assign ind1_o   = ind_reg[0];
    assign ind2_o   = ind_reg[1];
    assign ind3_o   = ind_reg[2];

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    property p_sel_link;
        (sel_w[2] == C_LINK) |=> (ind3_o == $past(link_i));
    endproperty
    a_sel_link: assert property (p_sel_link) else $error("link select wrong");

    property p_force_on;
        (sel_w[0] == C_ON) |=> ind1_o;
    endproperty
    a_force_on: assert property (p_force_on) else $error("force on failed");

    property p_dup_col;
        (sel_w[1] == C_DC && cnt_reg[1] == 7'h00 && !col_i)
            |=> (ind2_o == $past(link_i & duplex_i));
    endproperty
    a_dup_col: assert property (p_dup_col) else $error("duplex primary wrong");

    property p_col_blink;
        (sel_w[1] == C_DC && col_i) |=> (ind2_o == $past(fb_reg));
    endproperty
    a_col_blink: assert property (p_col_blink) else $error("collision no blink");

    property p_sel2_link;
        (sel_w[1] == C_LINK) |=> (ind2_o == $past(link_i));
    endproperty
    a_sel2_link: assert property (p_sel2_link) else $error("second link wrong");

    property p_act_blink;
        (sel_w[2] == C_LA && rx_i) |=> (ind3_o == $past(fb_reg));
    endproperty
    a_act_blink: assert property (p_act_blink) else $error("activity no blink");

    property p_comb_stretch;
        (sel_w[0] == C_LR && !str_en && rx_i) |=> (cnt_reg[0] != 7'h00);
    endproperty
    a_comb_stretch: assert property (p_comb_stretch) else $error("no stretch");

    property p_len30;
        (sel_w[0] == C_TX && str_en && tx_i && cfg_reg[FREQ_LSB +: 2] == 2'h0)
            |=> (cnt_reg[0] == STR0_MS);
    endproperty
    a_len30: assert property (p_len30) else $error("stretch length wrong");

    property p_no_stretch;
        (!str_en && sel_w[0] == C_TX) |=> (ind1_o == $past(tx_i));
    endproperty
    a_no_stretch: assert property (p_no_stretch) else $error("stretch not off");

    property p_read;
        (hit && !wb_we_i && adr_ok)
            |=> (wb_ack_o && wb_dat_o[15:0] == {$past(cfg_reg[15:1]), 1'b0});
    endproperty
    a_read: assert property (p_read) else $error("read data wrong");

    property p_hold;
        (cnt_reg[0] != 7'h00 && !tick_reg && !ev_w[0]) |=> $stable(cnt_reg[0]);
    endproperty
    a_hold: assert property (p_hold) else $error("hold timer moved");

    c_write: cover property (hit && wb_we_i && adr_ok);
    c_expire: cover property (cnt_reg[2] == 7'h01 && tick_reg);
    c_comb: cover property (sel_w[0] == C_LA && held_w[0] && !link_i);
    c_dc: cover property (sel_w[2] == C_DC && held_w[2]);
endmodule : ilc_top
`default_nettype wire

//--- verif/ilc_lamp.sv
`timescale 1ns/1ps
`default_nettype none
// Lamp on an indicator pin; it counts how often the lamp changes state.
module ilc_lamp (
    // Clock and reset.
    input  wire logic ref_clk_i,
    input  wire logic rstn_i,
    // Lamp drive, high lights the lamp.
    input  wire logic drive_i,
    // Observed lamp state.
    output logic      lit_o,
    output int        flips_o
);
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lit_o   <= 1'b0;
            flips_o <= 0;
        end else begin
            flips_o <= flips_o + ((drive_i !== lit_o) ? 1 : 0);
            lit_o   <= drive_i;
        end
    end
endmodule : ilc_lamp
`default_nettype wire

//--- verif/ilc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ilc_top_tb;
    import ilc_pkg::*;
    localparam int TK = 10;
    logic        ref_clk_i;
    logic        rstn_i;
    logic        cyc;
    logic        stb;
    logic        we;
    logic        ack;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [31:0] q;
    logic [5:0]  st;
    logic [2:0]  ind;
    logic        lit;
    int          flips;
    int          bad_count = 0;
    int          total_checks = 0;

    ilc_top #(.TICK_CYC_P(TK)) ilc_top_i (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .speed_i(st[5]), .tx_i(st[4]),
        .rx_i(st[3]), .col_i(st[2]), .link_i(st[1]), .duplex_i(st[0]),
        .ind1_o(ind[2]), .ind2_o(ind[1]), .ind3_o(ind[0]));
    ilc_lamp ilc_lamp_i (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .drive_i(ind[0]),
        .lit_o(lit), .flips_o(flips));

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic give_verdict;
        $display("Checks %0d, errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wb(input logic [7:0] a, input logic w, input logic [15:0] d);
        @(posedge ref_clk_i);
        adr <= a;
        we <= w;
        wdat <= {16'h0, d};
        sel <= 4'hf;
        cyc <= 1'b1;
        stb <= 1'b1;
        do begin
            @(posedge ref_clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic cfg(input logic [3:0] a, b, c, input logic [1:0] t, input logic e);
        wb(CFG_ADDR, 1'b1, {a, b, c, t, e, 1'b0});
    endtask : cfg

    task automatic pulse(input logic [5:0] base, input logic [5:0] ev);
        @(posedge ref_clk_i);
        st <= base | ev;
        @(posedge ref_clk_i);
        st <= base;
    endtask : pulse

    task automatic lows(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge ref_clk_i);
            c += (ind[0] === 1'b0) ? 1 : 0;
        end
    endtask : lows

    task automatic t_regs;
        wb(CFG_ADDR, 1'b0, 16'h0);
        chk(q, 32'h0422);
        wb(8'h16, 1'b0, 16'h0);
        chk(q, 32'h0);
        cfg(4'h5, 4'h3, 4'hd, 2'h2, 1'b0);
        wb(CFG_ADDR, 1'b0, 16'h0);
        chk(q, 32'h53d8);
    endtask : t_regs

    task automatic t_static;
        // Only defined codes are programmed.
        logic [3:0] cd[9] = '{C_SPEED, C_TX, C_RX, C_COL, C_LINK, C_DUP, C_ACT, C_ON, C_OFF};
        logic [5:0] mk[9] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01, 6'h18, 6'h00, 6'h3f};
        for (int i = 0; i < 9; i++) begin
            cfg(cd[i], cd[i], cd[i], 2'h0, 1'b0);
            st <= mk[i];
            repeat (3) @(posedge ref_clk_i);
            chk(ind, {3{cd[i] != C_OFF}});
            st <= ~mk[i];
            repeat (3) @(posedge ref_clk_i);
            chk(ind, {3{cd[i] == C_ON}});
            st <= 6'h0;
        end
    endtask : t_static

    task automatic t_stretch;
        int d[3] = '{300, 600, 1000};
        for (int t = 0; t < 3; t++) begin
            cfg(C_TX, C_TX, C_TX, t[1:0], 1'b1);
            pulse(6'h0, 6'h10);
            repeat (d[t] - 50) @(posedge ref_clk_i);
            chk(ind, 3'h7);
            repeat (80) @(posedge ref_clk_i);
            chk(ind, 3'h0);
        end
        cfg(C_TX, C_TX, C_TX, 2'h0, 1'b1);
        pulse(6'h0, 6'h10);
        repeat (200) @(posedge ref_clk_i);
        pulse(6'h0, 6'h10);
        repeat (250) @(posedge ref_clk_i);
        chk(ind, 3'h7);
        repeat (80) @(posedge ref_clk_i);
        chk(ind, 3'h0);
        cfg(C_TX, C_TX, C_TX, 2'h0, 1'b0);
        pulse(6'h0, 6'h10);
        repeat (3) @(posedge ref_clk_i);
        chk(ind, 3'h0);
    endtask : t_stretch

    task automatic t_blink;
        int f0;
        int fa;
        cfg(C_SPEED, C_LINK, C_FAST, 2'h0, 1'b1);
        repeat (3) @(posedge ref_clk_i);
        f0 = flips;
        repeat (2000) @(posedge ref_clk_i);
        fa = flips - f0;
        cfg(C_SPEED, C_LINK, C_SLOW, 2'h0, 1'b1);
        repeat (3) @(posedge ref_clk_i);
        f0 = flips;
        repeat (2000) @(posedge ref_clk_i);
        chk(fa >= 3, 1'b1);
        chk(flips - f0 <= 1, 1'b1);
    endtask : t_blink

    task automatic t_comb;
        int c;
        cfg(C_SPEED, C_LINK, C_LR, 2'h2, 1'b0);
        st <= 6'h02;
        repeat (3) @(posedge ref_clk_i);
        chk(ind[0], 1'b1);
        pulse(6'h02, 6'h08);
        lows(900, c);
        chk(c > 100, 1'b1);
        repeat (200) @(posedge ref_clk_i);
        chk(ind[0], 1'b1);
        cfg(C_SPEED, C_LINK, C_LA, 2'h2, 1'b0);
        pulse(6'h00, 6'h10);
        lows(900, c);
        chk(c < 800, 1'b1);
        repeat (200) @(posedge ref_clk_i);
        chk(ind[0], 1'b0);
        cfg(C_SPEED, C_LINK, C_DC, 2'h2, 1'b0);
        st <= 6'h03;
        repeat (3) @(posedge ref_clk_i);
        chk(ind[0], 1'b1);
        chk(lit, 1'b1);
        pulse(6'h03, 6'h04);
        lows(900, c);
        chk(c > 100, 1'b1);
    endtask : t_comb

    initial begin
        rstn_i = 1'b0;
        st = 6'h0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h0;
        sel = 4'h0;
        wdat = 32'h0;
        repeat (12) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        t_regs();
        t_static();
        t_stretch();
        t_blink();
        t_comb();
        give_verdict();
    end

    initial begin
        repeat (60000) @(posedge ref_clk_i);
        bad_count++;
        give_verdict();
    end
endmodule : ilc_top_tb
`default_nettype wire
